// ---- src/lmsc_defines.svh ----
// Named constants for the LED matrix serial controller.
`ifndef LMSC_DEFINES_SVH
`define LMSC_DEFINES_SVH

// Command opcodes held in the top two bits of a command byte.
`define LMSC_OP_DMODE    2'h0
`define LMSC_OP_DATA     2'h1
`define LMSC_OP_CTRL     2'h2
`define LMSC_OP_ADDR     2'h3

// Data setting command: write or key read selection.
`define LMSC_RW_WRITE    2'h0
`define LMSC_RW_READ     2'h2

// Display mode codes and the grid count of each mode.
`define LMSC_MODE_8X4    2'h0
`define LMSC_MODE_7X5    2'h1
`define LMSC_GRIDS_8X4   3'h4
`define LMSC_GRIDS_7X5   3'h5

// Display RAM addressing.
`define LMSC_ADDR_LIMIT  4'hA
`define LMSC_AUTO_MAX    4'hE
`define LMSC_SHARED_BIT  5

// Serial byte framing and key byte layout.
`define LMSC_BIT_LAST    3'h7
`define LMSC_KEY_BIT_A   3'h0
`define LMSC_KEY_BIT_B   3'h3
`define LMSC_KEY_COUNT   3'h7

// Scan timing: sixteen duty steps per grid slot.
`define LMSC_SUB_LAST    4'hF
`define LMSC_QUARTER_END 2'h3
`define LMSC_MCLK_KHZ    100000
`define LMSC_OSC_KHZ     500

// Grid on-time in sixteenths for each dimming code.
`define LMSC_DUTY0       5'h01
`define LMSC_DUTY1       5'h02
`define LMSC_DUTY2       5'h04
`define LMSC_DUTY3       5'h0A
`define LMSC_DUTY4       5'h0B
`define LMSC_DUTY5       5'h0C
`define LMSC_DUTY6       5'h0D
`define LMSC_DUTY7       5'h0E

`endif

// ---- src/lmsc_pkg.sv ----
// Types shared by the LED matrix serial controller.
package lmsc_pkg;

	// Serial receiver states.
	typedef enum logic [1:0] {
		LMSC_RX_IDLE = 2'b00,
		LMSC_RX_CMD  = 2'b01,
		LMSC_RX_DATA = 2'b10,
		LMSC_RX_READ = 2'b11
	} lmsc_rx_e;

	typedef logic [7:0] lmsc_byte_t;
	typedef logic [6:0] lmsc_seg_t;
	typedef logic [3:0] lmsc_grid_t;

endpackage

// ---- src/lmsc_fifo.sv ----
// Small synchronous FIFO that carries received bytes to the command decoder.
`timescale 1ns/10ps
module lmsc_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 8
) (
	input  logic         mclk_i,
	input  logic         rst_i,
	input  logic         in_valid_i,
	output logic         in_ready_o,
	input  logic [W-1:0] in_data_i,
	output logic         out_valid_o,
	input  logic         out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	// Pointers carry one extra bit so full and empty stay distinct.
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             wp;
		logic [AW:0]             rp;
	} lmsc_fifo_s;

	lmsc_fifo_s r;
	lmsc_fifo_s n;
	logic       full;
	logic       empty;

	// The pointer arithmetic only works for a power-of-two depth.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("lmsc_fifo depth must be a power of two of at least two");
	end

	// Status and read data come straight from the registered state.
	assign full        = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
	assign empty       = (r.wp == r.rp);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = r.mem[r.rp[AW-1:0]];

	// Next state: write on an accepted push, advance on an accepted pop.
	always_comb begin
		n = r;
		if (in_valid_i && !full) begin
			n.mem[r.wp[AW-1:0]] = in_data_i;
			n.wp                = r.wp + 1'b1;
		end
		if (out_ready_i && !empty) begin
			n.rp = r.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	property p_no_overflow;
		@(posedge mclk_i) disable iff (rst_i)
		full |=> (r.wp == $past(r.wp));
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("FIFO written while full");
	c_full: cover property (@(posedge mclk_i) disable iff (rst_i) full);
endmodule

// ---- src/lmsc_top.sv ----
// LED matrix serial controller: serial command link, display scan and key scan.
`timescale 1ns/10ps
`include "lmsc_defines.svh"
module lmsc_top #(
	parameter int OSC_DIV    = `LMSC_MCLK_KHZ / `LMSC_OSC_KHZ,
	parameter int FIFO_DEPTH = 8
) (
	input  logic               mclk_i,
	input  logic               rst_i,
	input  logic               shift_clock_i,
	input  logic               frame_strobe_i,
	input  logic               serial_data_i,
	output logic               serial_data_o,
	output logic               serial_data_oe_n_o,
	input  logic               key_return_input_i,
	output lmsc_pkg::lmsc_seg_t  segment_key_source_o,
	output logic               shared_segment_grid_o,
	output lmsc_pkg::lmsc_grid_t grid_outputs_o,
	output logic               display_on_o,
	output logic               test_mode_o,
	output lmsc_pkg::lmsc_seg_t  key_state_o
);
	import lmsc_pkg::*;

	localparam int DIV_W = (OSC_DIV > 2) ? $clog2(OSC_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

	// The scan needs at least two clocks per oscillator step.
	if (OSC_DIV < 2) begin : g_bad_div
		$error("lmsc_top OSC_DIV must be at least two");
	end

	// Every piece of state of the controller.
	typedef struct packed {
		logic              sclk_s1;
		logic              sclk_s2;
		logic              sclk_d;
		logic              stb_s1;
		logic              stb_s2;
		logic              stb_d;
		logic              din_s1;
		logic              din_s2;
		logic              key_s1;
		logic              key_s2;
		lmsc_rx_e          rx_state;
		logic [7:0]        rx_sh;
		logic [2:0]        rx_cnt;
		logic              rx_first;
		logic              push_v;
		logic [8:0]        push_d;
		logic              tx_started;
		logic [2:0]        tx_byte;
		logic [2:0]        tx_bit;
		logic              tx_val;
		logic              dio_low;
		logic              busy;
		logic [1:0]        rw_mode;
		logic              fixed;
		logic              test;
		logic [1:0]        disp_mode;
		logic              disp_on;
		logic [2:0]        duty;
		logic [3:0]        addr;
		logic              data_ok;
		logic [3:0]        wr_cnt;
		logic              fixed_done;
		logic [9:0][7:0]   ram;
		logic [6:0]        key_ram;
		logic [DIV_W-1:0]  div;
		logic [3:0]        sub;
		logic [2:0]        slot;
		logic              frame_par;
		logic [6:0]        seg;
		logic              shared;
		logic [3:0]        grid;
	} lmsc_state_s;

	lmsc_state_s r;
	lmsc_state_s n;

	logic       sclk_rise;
	logic       sclk_fall;
	logic       stb_rise;
	logic       stb_fall;
	logic       tick;
	logic       pop;
	logic       f_valid;
	logic       f_in_ready;
	logic [8:0] f_data;
	logic [7:0] pb;
	logic [7:0] rx_byte;
	logic [2:0] grids;
	logic [3:0] dig;
	logic [2:0] kidx;
	logic       lit;
	logic       wr_ok;

	// Grid on-time in sixteenths for a dimming code.
	function automatic logic [4:0] duty_steps(input logic [2:0] code);
		unique case (code)
			3'h0: duty_steps = `LMSC_DUTY0;
			3'h1: duty_steps = `LMSC_DUTY1;
			3'h2: duty_steps = `LMSC_DUTY2;
			3'h3: duty_steps = `LMSC_DUTY3;
			3'h4: duty_steps = `LMSC_DUTY4;
			3'h5: duty_steps = `LMSC_DUTY5;
			3'h6: duty_steps = `LMSC_DUTY6;
			3'h7: duty_steps = `LMSC_DUTY7;
		endcase
	endfunction

	// Key bit for a given read byte and bit; other bits read as released.
	function automatic logic key_bit(input logic [6:0] k, input logic [2:0] byt,
			input logic [2:0] bt);
		logic [3:0] idx;
		idx = {byt, 1'b0};
		key_bit = 1'b1;
		if (bt == `LMSC_KEY_BIT_A || bt == `LMSC_KEY_BIT_B) begin
			idx = {byt, (bt == `LMSC_KEY_BIT_B)};
			if (idx < {1'b0, `LMSC_KEY_COUNT}) begin
				key_bit = k[idx[2:0]];
			end
		end
	endfunction

	// Edge detection looks only at the second and third synchroniser stages.
	assign sclk_rise = r.sclk_s2 & ~r.sclk_d;
	assign sclk_fall = ~r.sclk_s2 & r.sclk_d;
	assign stb_rise  = r.stb_s2 & ~r.stb_d;
	assign stb_fall  = ~r.stb_s2 & r.stb_d;
	assign tick      = (r.div == DIV_LAST);
	assign rx_byte   = {r.din_s2, r.rx_sh[7:1]};

	// The decoder takes one byte every other cycle, far faster than bytes arrive, so the FIFO never fills.
	assign pop   = f_valid & ~r.busy;
	assign pb    = f_data[7:0];
	assign wr_ok = r.data_ok && (r.rw_mode == `LMSC_RW_WRITE) && (r.addr < `LMSC_ADDR_LIMIT)
		&& (r.wr_cnt < `LMSC_AUTO_MAX) && !(r.fixed && r.fixed_done);

	// Scan geometry derived from the mode, the current slot, the duty step and the frame parity.
	assign grids = (r.disp_mode == `LMSC_MODE_7X5) ? `LMSC_GRIDS_7X5 : `LMSC_GRIDS_8X4;
	assign dig   = {r.slot, 1'b0};
	assign kidx  = {r.frame_par, r.sub[3:2]};
	assign lit   = r.disp_on && ({1'b0, r.sub} < duty_steps(r.duty));

	lmsc_fifo #(
		.W     (9),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (r.push_v),
		.in_ready_o  (f_in_ready),
		.in_data_i   (r.push_d),
		.out_valid_o (f_valid),
		.out_ready_i (~r.busy),
		.out_data_o  (f_data)
	);

	// Next-state logic for the whole controller.
	always_comb begin
		n = r;
		// Two-stage synchronisers for every pin input.
		n.sclk_s1 = shift_clock_i;
		n.sclk_s2 = r.sclk_s1;
		n.sclk_d  = r.sclk_s2;
		n.stb_s1  = frame_strobe_i;
		n.stb_s2  = r.stb_s1;
		n.stb_d   = r.stb_s2;
		n.din_s1  = serial_data_i;
		n.din_s2  = r.din_s1;
		n.key_s1  = key_return_input_i;
		n.key_s2  = r.key_s1;

		// A pending byte waits here while the FIFO is full.
		if (f_in_ready) begin
			n.push_v = 1'b0;
		end

		// Serial receiver and key data transmitter.
		if (r.stb_s2) begin
			n.rx_state   = LMSC_RX_IDLE;
			n.rx_cnt     = 3'h0;
			n.tx_started = 1'b0;
		end else if (stb_fall) begin
			n.rx_state = LMSC_RX_CMD;
			n.rx_cnt   = 3'h0;
			n.rx_first = 1'b1;
		end else begin
			unique case (r.rx_state)
				LMSC_RX_IDLE: begin
				end
				LMSC_RX_CMD, LMSC_RX_DATA: begin
					if (sclk_rise) begin
						n.rx_sh  = rx_byte;
						n.rx_cnt = r.rx_cnt + 3'h1;
						if (r.rx_cnt == `LMSC_BIT_LAST) begin
							n.push_v   = 1'b1;
							n.push_d   = {r.rx_first, rx_byte};
							n.rx_first = 1'b0;
							n.rx_state = LMSC_RX_DATA;
							// A key read turns the link round at once; the host's wait covers
							// the decoder's latency.
							if (r.rx_first && rx_byte[7:6] == `LMSC_OP_DATA
									&& rx_byte[1:0] == `LMSC_RW_READ) begin
								n.rx_state   = LMSC_RX_READ;
								n.tx_started = 1'b0;
							end
						end
					end
				end
				LMSC_RX_READ: begin
					if (sclk_fall) begin
						if (!r.tx_started) begin
							n.tx_started = 1'b1;
							n.tx_byte    = 3'h0;
							n.tx_bit     = 3'h0;
						end else if (r.tx_bit == `LMSC_BIT_LAST) begin
							n.tx_bit  = 3'h0;
							n.tx_byte = r.tx_byte + 3'h1;
						end else begin
							n.tx_bit = r.tx_bit + 3'h1;
						end
						n.tx_val = key_bit(r.key_ram, n.tx_byte, n.tx_bit);
					end
				end
			endcase
		end
		// Open drain: pull low for a zero, otherwise let the line float.
		n.dio_low = (n.rx_state == LMSC_RX_READ) && n.tx_started && !n.tx_val;

		// Command decoder and display RAM writes.
		n.busy = pop;
		if (pop) begin
			if (f_data[8]) begin
				n.data_ok = 1'b0;
				unique case (pb[7:6])
					`LMSC_OP_DMODE: begin
						if (!pb[1]) begin
							n.disp_mode = pb[1:0];
						end
					end
					`LMSC_OP_DATA: begin
						n.test    = pb[3];
						n.fixed   = pb[2];
						n.rw_mode = pb[1:0];
					end
					`LMSC_OP_CTRL: begin
						n.disp_on = pb[3];
						n.duty    = pb[2:0];
					end
					`LMSC_OP_ADDR: begin
						n.addr       = pb[3:0];
						n.data_ok    = 1'b1;
						n.wr_cnt     = 4'h0;
						n.fixed_done = 1'b0;
					end
				endcase
			end else if (wr_ok) begin
				// An address at or past the limit fails wr_ok and stays stuck.
				n.ram[r.addr]  = pb;
				n.wr_cnt       = r.wr_cnt + 4'h1;
				n.fixed_done   = 1'b1;
				if (!r.fixed) begin
					n.addr = r.addr + 4'h1;
				end
			end
		end

		// Oscillator divider, duty steps, grid slots and frame parity.
		n.div = tick ? '0 : r.div + 1'b1;
		if (tick) begin
			n.sub = r.sub + 4'h1;
			if (r.sub == `LMSC_SUB_LAST) begin
				// A mode change can leave the slot past the key slot, so wrap on >=.
				if (r.slot >= grids) begin
					n.slot      = 3'h0;
					n.frame_par = ~r.frame_par;
				end else begin
					n.slot = r.slot + 3'h1;
				end
			end
			// Key input is latched at the end of each key source quarter.
			if (r.slot == grids && r.sub[1:0] == `LMSC_QUARTER_END && kidx < `LMSC_KEY_COUNT) begin
				n.key_ram[kidx] = r.key_s2;
			end
		end

		// Registered pin outputs for the current slot.
		n.seg    = 7'h00;
		n.shared = 1'b0;
		n.grid   = 4'h0;
		if (r.slot == grids) begin
			if (kidx < `LMSC_KEY_COUNT) begin
				n.seg = 7'h01 << kidx;
			end
		end else if (lit && r.slot < grids) begin
			n.seg = r.ram[dig][6:0];
			if (r.disp_mode == `LMSC_MODE_7X5) begin
				n.shared = (r.slot == `LMSC_GRIDS_8X4);
			end else begin
				n.shared = r.ram[dig + 4'h1][`LMSC_SHARED_BIT];
			end
			if (r.slot < `LMSC_GRIDS_8X4) begin
				n.grid = 4'h1 << r.slot[1:0];
			end
		end
	end

	// All state resets to zero: normal, auto-increment, write, address zero.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// The data line never drives high; only its enable moves.
	assign serial_data_o         = 1'b0;
	assign serial_data_oe_n_o    = ~r.dio_low;
	assign segment_key_source_o  = r.seg;
	assign shared_segment_grid_o = r.shared;
	assign grid_outputs_o        = r.grid;
	assign display_on_o          = r.disp_on;
	assign test_mode_o           = r.test;
	assign key_state_o           = r.key_ram;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_lsb_first;
		(sclk_rise && !r.stb_s2 && !stb_fall && (r.rx_state == LMSC_RX_CMD
			|| r.rx_state == LMSC_RX_DATA)) |=> (r.rx_sh[7] == $past(r.din_s2));
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("Bit not shifted in at MSB");

	property p_tx_on_fall;
		$changed(r.tx_val) |-> $past(sclk_fall);
	endproperty
	a_tx_on_fall: assert property (p_tx_on_fall) else $error("Read bit moved off fall");

	property p_stb_ignore;
		r.stb_s2 |=> (r.rx_state == LMSC_RX_IDLE && r.rx_cnt == 3'h0 && !r.dio_low);
	endproperty
	a_stb_ignore: assert property (p_stb_ignore) else $error("Active with strobe high");

	property p_abort;
		(stb_rise && r.rx_cnt != 3'h0) |=> ##1 !(r.push_v && !$past(r.push_v));
	endproperty
	a_abort: assert property (p_abort) else $error("Partial byte pushed");

	property p_mode;
		(pop && f_data[8] && pb[7:6] == `LMSC_OP_DMODE && !pb[1])
			|=> (r.disp_mode == $past(pb[1:0]));
	endproperty
	a_mode: assert property (p_mode) else $error("Display mode not taken");

	property p_bad_addr;
		(pop && !f_data[8] && r.addr >= `LMSC_ADDR_LIMIT) |=> (r.ram == $past(r.ram));
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("Write at invalid address");

	property p_auto_inc;
		(pop && !f_data[8] && wr_ok && !r.fixed) |=> (r.addr == $past(r.addr) + 4'h1);
	endproperty
	a_auto_inc: assert property (p_auto_inc) else $error("Address did not advance");

	property p_duty;
		(r.grid != 4'h0) |-> ({1'b0, $past(r.sub)} < duty_steps($past(r.duty)));
	endproperty
	a_duty: assert property (p_duty) else $error("Grid lit outside duty window");

	property p_blank;
		(!r.disp_on && r.slot != grids) |=> (r.grid == 4'h0 && r.seg == 7'h00);
	endproperty
	a_blank: assert property (p_blank) else $error("Display lit while off");

	property p_release;
		(r.rx_state != LMSC_RX_READ) |-> !r.dio_low;
	endproperty
	a_release: assert property (p_release) else $error("Data line held outside key read");

	c_key_read: cover property (r.rx_state == LMSC_RX_READ && sclk_fall && r.tx_started);
	c_write: cover property (pop && !f_data[8] && wr_ok);
	c_grid5: cover property (r.shared && r.disp_mode == `LMSC_MODE_7X5);
	c_key_latch: cover property (tick && r.slot == grids && r.key_s2);
endmodule

// ---- tb/lmsc_host_model.sv ----
// Host model that drives the strobe, shift clock and data line of the serial link.
`timescale 1ns/10ps
module lmsc_host_model #(
	parameter int HALF = 6
) (
	input  wire logic mclk_i,
	input  wire logic dev_oe_n_i,
	input  wire logic dev_data_i,
	output logic      shift_clock_o,
	output logic      frame_strobe_o,
	output logic      line_o
);
	logic host_oe_r;
	logic host_bit_r;

	// The line has a pull-up, so a released line reads high; both parties only pull it low.
	assign line_o = (host_oe_r ? host_bit_r : 1'b1) & (dev_oe_n_i ? 1'b1 : dev_data_i);

	// The link rests with strobe high, clock high and the line released.
	initial begin
		shift_clock_o  = 1'b1;
		frame_strobe_o = 1'b1;
		host_oe_r      = 1'b0;
		host_bit_r     = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic start_frame();
		frame_strobe_o <= 1'b0;
		wait_cyc(HALF);
	endtask

	// Data changes with the falling clock and stays put across the rising edge.
	task automatic put_bits(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			shift_clock_o <= 1'b0;
			host_oe_r     <= 1'b1;
			host_bit_r    <= b[i];
			wait_cyc(HALF);
			shift_clock_o <= 1'b1;
			wait_cyc(HALF);
		end
	endtask

	// The bit is taken just before the rising edge, well after the device moved it.
	task automatic get_byte(output logic [7:0] b);
		host_oe_r <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			shift_clock_o <= 1'b0;
			wait_cyc(HALF);
			b[i] = line_o;
			shift_clock_o <= 1'b1;
			wait_cyc(HALF);
		end
	endtask

	task automatic end_frame();
		wait_cyc(HALF);
		frame_strobe_o <= 1'b1;
		host_oe_r      <= 1'b0;
		wait_cyc(2 * HALF);
	endtask
endmodule

// ---- tb/tb_lmsc_top.sv ----
// Self-checking testbench of the LED matrix serial controller.
`timescale 1ns/10ps
module tb_lmsc_top;
	import lmsc_pkg::*;
	localparam int OSC = 2;
	localparam int DUTY_TAB[8] = '{1, 2, 4, 10, 11, 12, 13, 14};

	logic                mclk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                key_return_input_i = 1'b0;
	logic                sclk;
	logic                stb;
	logic                line;
	logic                serial_data_o;
	logic                serial_data_oe_n_o;
	lmsc_seg_t           segment_key_source_o;
	logic                shared_segment_grid_o;
	lmsc_grid_t          grid_outputs_o;
	logic                display_on_o;
	logic                test_mode_o;
	lmsc_seg_t           key_state_o;
	logic [7:0]          ram[10];
	logic [6:0]          keys = 7'h00;
	logic [15:0]         rs = 16'h0041;
	logic                scan_en = 1'b0;
	int                  m_mode, m_duty, m_on, m_test, m_fixed, m_rw;
	int                  error_cnt, n_compared, cyc;

	// The clock toggles every 5 ns, a period of 10 ns.
	always #5 mclk_i = ~mclk_i;

	lmsc_top #(.OSC_DIV(OSC), .FIFO_DEPTH(8)) i_lmsc_top (
		.mclk_i(mclk_i), .rst_i(rst_i), .shift_clock_i(sclk), .frame_strobe_i(stb),
		.serial_data_i(line), .serial_data_o(serial_data_o),
		.serial_data_oe_n_o(serial_data_oe_n_o), .key_return_input_i(key_return_input_i),
		.segment_key_source_o(segment_key_source_o),
		.shared_segment_grid_o(shared_segment_grid_o), .grid_outputs_o(grid_outputs_o),
		.display_on_o(display_on_o), .test_mode_o(test_mode_o), .key_state_o(key_state_o));

	lmsc_host_model #(.HALF(6)) i_lmsc_host_model (
		.mclk_i(mclk_i), .dev_oe_n_i(serial_data_oe_n_o), .dev_data_i(serial_data_o),
		.shift_clock_o(sclk), .frame_strobe_o(stb), .line_o(line));

	function automatic logic [7:0] rnd();
		rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
		return rs[7:0];
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Sends one whole frame and applies it to the bench model of the command decoder.
	task automatic frame(input logic [7:0] q[$]);
		int a;
		i_lmsc_host_model.start_frame();
		foreach (q[k]) i_lmsc_host_model.put_bits(q[k], 8);
		i_lmsc_host_model.end_frame();
		a = q[0][3:0];
		case (q[0][7:6])
			2'h0: if (q[0][1:0] < 2) m_mode = q[0][0];
			2'h1: begin
				m_test = q[0][3];
				m_fixed = q[0][2];
				m_rw = q[0][1:0];
			end
			2'h2: begin
				m_duty = q[0][2:0];
				m_on = q[0][3];
			end
			default: for (int k = 1; k < q.size(); k++) begin
				if (m_rw == 0 && a < 10 && k < 15 && !(m_fixed && k > 1)) begin
					ram[a] = q[k];
					a = m_fixed ? a : a + 1;
				end
				else if (a < 10)
					a = a;
			end
		endcase
	endtask

	// Measures one whole on-time of the first grid, in clock cycles.
	task automatic duty_run(output int n);
		n = 0;
		for (int w = 0; w < 400 && grid_outputs_o[0] === 1'b1; w++) @(posedge mclk_i);
		for (int w = 0; w < 400 && grid_outputs_o[0] !== 1'b1; w++) @(posedge mclk_i);
		while (grid_outputs_o[0] === 1'b1 && n < 400) begin
			n++;
			@(posedge mclk_i);
		end
	endtask

	// A closed key answers when its source line is high during the key slot.
	always @(posedge mclk_i)
		key_return_input_i <= (grid_outputs_o == 4'h0) && |(segment_key_source_o & keys);

	// Watchdog, open-drain check and the scan comparison against the bench model.
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (serial_data_oe_n_o === 1'b0)
			chk("serial_data_o", 8'h00, {7'h0, serial_data_o});
		if (scan_en) begin
			chk("one_grid", 8'h00, {4'h0, grid_outputs_o & (grid_outputs_o - 4'h1)});
			for (int s = 0; s < 4; s++)
				if (grid_outputs_o[s] === 1'b1) begin
					chk("segments", {1'b0, ram[2*s][6:0]}, {1'b0, segment_key_source_o});
					if (m_mode == 0)
						chk("shared", {7'h0, ram[2*s+1][5]}, {7'h0, shared_segment_grid_o});
					else
						chk("shared_off", 8'h00, {7'h0, shared_segment_grid_o});
				end
			if (grid_outputs_o === 4'h0 && m_mode == 1 && shared_segment_grid_o === 1'b1)
				chk("grid5_segs", {1'b0, ram[8][6:0]}, {1'b0, segment_key_source_o});
			if (grid_outputs_o === 4'h0 && shared_segment_grid_o !== 1'b1)
				chk("key_source", 8'h00,
					{1'b0, segment_key_source_o & (segment_key_source_o - 7'h1)});
		end
		// The limit is checked last so that nothing runs after the run ends.
		if (cyc == 60000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		logic [7:0] q[$];
		logic [7:0] b;
		logic [7:0] kb;
		int         n;
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk("display_on", 8'h00, {7'h0, display_on_o});
		chk("test_mode", 8'h00, {7'h0, test_mode_o});
		chk("line_release", 8'h01, {7'h0, serial_data_oe_n_o});
		chk("key_state", 8'h00, {1'b0, key_state_o});
		// Host start-up: clear the whole RAM, then fill it with random bytes.
		frame('{8'h40});
		q = '{8'hC0};
		repeat (10) q.push_back(8'h00);
		frame(q);
		q = '{8'hC0};
		repeat (10) q.push_back(rnd());
		frame(q);
		frame('{8'h00});
		frame('{8'h8F});
		chk("display_on", 8'h01, {7'h0, display_on_o});
		repeat (200) @(posedge mclk_i);
		scan_en <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			frame('{8'h88 | c[7:0]});
			duty_run(n);
			chk("duty_cycles", 8'(DUTY_TAB[c] * OSC), n[7:0]);
		end
		scan_en <= 1'b0;
		frame('{8'h48});
		chk("test_mode", 8'h01, {7'h0, test_mode_o});
		frame('{8'h44});
		frame('{8'hC2, rnd(), rnd()});
		frame('{8'h40});
		frame('{8'hCA, rnd()});
		frame('{8'hC8, rnd(), rnd(), rnd()});
		chk("test_mode", 8'h00, {7'h0, test_mode_o});
		frame('{8'h01});
		repeat (200) @(posedge mclk_i);
		scan_en <= 1'b1;
		repeat (400) @(posedge mclk_i);
		scan_en <= 1'b0;
		frame('{8'h00});
		// Clocks while strobe is high, then a byte cut short by strobe, change nothing.
		i_lmsc_host_model.put_bits(8'h80, 8);
		chk("display_on", 8'h01, {7'h0, display_on_o});
		i_lmsc_host_model.start_frame();
		i_lmsc_host_model.put_bits(8'h80, 5);
		i_lmsc_host_model.end_frame();
		chk("display_on", 8'h01, {7'h0, display_on_o});
		frame('{8'h80});
		chk("display_on", 8'h00, {7'h0, display_on_o});
		frame('{8'h8F});
		keys <= 7'(rnd());
		repeat (700) @(posedge mclk_i);
		chk("key_state", {1'b0, keys}, {1'b0, key_state_o});
		kb = {1'b1, keys};
		i_lmsc_host_model.start_frame();
		i_lmsc_host_model.put_bits(8'h42, 8);
		i_lmsc_host_model.wait_cyc(100);
		for (int k = 0; k < 5; k++) begin
			i_lmsc_host_model.get_byte(b);
			chk("key_byte", k < 4 ? {4'hF, kb[2*k+1], 2'b11, kb[2*k]} : 8'hFF, b);
		end
		i_lmsc_host_model.end_frame();
		chk("line_release", 8'h01, {7'h0, serial_data_oe_n_o});
		conclude();
	end
endmodule
